// ===== erf_regs.svh
// register offsets, field positions, reset values and codes of the rx filter
`ifndef ERF_REGS_SVH
`define ERF_REGS_SVH

// ------------------------------------------------------------------------
// register map
// ------------------------------------------------------------------------
`define ERF_OFS_RX_FILTER_CONFIG 4'h0
`define ERF_OFS_CONTROL          4'h4
`define ERF_OFS_STATUS           4'h8
`define ERF_ADDR_W               4

// ------------------------------------------------------------------------
// rx_filter_config fields and reset
// ------------------------------------------------------------------------
`define ERF_CFG_RESET            32'h0000_0000
`define ERF_CFG_WMASK            32'h0000_dfff
`define ERF_BIT_HASH_EN          15
`define ERF_BIT_WAKE_EN          14
`define ERF_BIT_INVERT           12
`define ERF_SEL_HI               11
`define ERF_SEL_LO               8
`define ERF_BIT_CRC_BAD          7
`define ERF_BIT_CRC_GOOD         6
`define ERF_BIT_SHORT_ERR        5
`define ERF_BIT_SHORT            4
`define ERF_BIT_SINGLE           3
`define ERF_BIT_FOREIGN          2
`define ERF_BIT_GROUP            1
`define ERF_BIT_ALL              0

// control register: bit 0 receive_enable
`define ERF_BIT_RX_EN            0

// axi response codes
`define ERF_RESP_OKAY            2'h0
`define ERF_RESP_SLVERR          2'h2

`endif

// ===== erf_pkg.sv
// types shared by the rx filter design
package erf_pkg;
    typedef enum logic [3:0] {
        ERF_PM_OFF      = 4'b0000,
        ERF_PM_CSUM     = 4'b0001,
        ERF_PM_STA_A    = 4'b0010,
        ERF_PM_STA_B    = 4'b0011,
        ERF_PM_UNI_A    = 4'b0100,
        ERF_PM_UNI_B    = 4'b0101,
        ERF_PM_BCAST_A  = 4'b0110,
        ERF_PM_BCAST_B  = 4'b0111,
        ERF_PM_HASH     = 4'b1000,
        ERF_PM_WAKE     = 4'b1001
    } erf_pm_sel_e;

    typedef logic [1:0] erf_resp_t;
endpackage

// ===== erf_pattern_judge.sv
// combinational pattern-match decision for one frame
`timescale 1ns/1ps
`include "erf_regs.svh"
module erf_pattern_judge (
    input  wire logic [3:0] sel,
    input  wire logic       invert,
    input  wire logic       csum_match,
    input  wire logic       dest_station,
    input  wire logic       dest_unicast,
    input  wire logic       dest_broadcast,
    input  wire logic       hash_match,
    input  wire logic       wake_packet,
    output logic            success
);
    import erf_pkg::*;

    logic base;
    logic sta_hit;
    logic uni_hit;
    logic bc_hit;
    logic hash_hit;
    logic wake_hit;

    // per-mode terms; hash and wake ignore their filter enables on purpose
    assign base     = invert ^ csum_match;
    assign sta_hit  = base & dest_station;
    assign uni_hit  = base & dest_unicast;
    assign bc_hit   = base & dest_broadcast;
    assign hash_hit = base & hash_match;
    assign wake_hit = base & wake_packet;

    // ------------------------------------------------------------------------
    // mode decode; codes above 1001 never succeed
    // ------------------------------------------------------------------------
    always_comb begin
        unique case (sel)
            ERF_PM_OFF:                     success = 1'b0;
            ERF_PM_CSUM:                    success = base;
            ERF_PM_STA_A, ERF_PM_STA_B:     success = sta_hit;
            ERF_PM_UNI_A, ERF_PM_UNI_B:     success = uni_hit;
            ERF_PM_BCAST_A, ERF_PM_BCAST_B: success = bc_hit;
            ERF_PM_HASH:                    success = hash_hit;
            ERF_PM_WAKE:                    success = wake_hit;
            default:                        success = 1'b0;
        endcase
    end
endmodule

// ===== erf_rx_filter.sv
// receive frame filter: axi4-lite registers and per-frame accept decision
`timescale 1ns/1ps
`include "erf_regs.svh"
module erf_rx_filter (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output erf_pkg::erf_resp_t s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output erf_pkg::erf_resp_t s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // frame classification from the receive path, valid with frame_done
    input  wire logic        frame_done,
    input  wire logic        crc_bad,
    input  wire logic        short_frame,
    input  wire logic        dest_station,
    input  wire logic        dest_unicast,
    input  wire logic        dest_multicast,
    input  wire logic        dest_broadcast,
    input  wire logic        hash_match,
    input  wire logic        wake_packet,
    input  wire logic        csum_match,
    // results
    output logic             frame_accept,
    output logic             frame_reject,
    output logic             pattern_hit,
    output logic             receive_enable
);
    import erf_pkg::*;

    // ------------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------------
    logic [31:0] cfg_r;
    logic        rx_en_r;
    logic        aw_held_r;
    logic        w_held_r;
    logic [3:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        bvalid_r;
    erf_resp_t   bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    erf_resp_t   rresp_r;
    logic        accept_r;
    logic        reject_r;
    logic        hit_r;
    logic [7:0]  acc_cnt_r;
    logic [7:0]  rej_cnt_r;
    logic        awready_r;
    logic        wready_r;
    logic        arready_r;

    // ------------------------------------------------------------------------
    // write channel capture, address and data in either order
    // ------------------------------------------------------------------------
    wire aw_fire  = s_axi_awvalid & awready_r;
    wire w_fire   = s_axi_wvalid & wready_r;
    wire aw_have  = aw_held_r | aw_fire;
    wire w_have   = w_held_r | w_fire;
    wire wr_go    = aw_have & w_have & ~bvalid_r;
    wire [3:0]  wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
    wire [3:0]  wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;

    // readies are registered predictions of next cycle's idle state, so the
    // ports come from flops without losing a cycle between transfers
    wire bvalid_nxt  = wr_go | (bvalid_r & ~s_axi_bready);
    wire awready_nxt = ~(aw_have & ~wr_go) & ~bvalid_nxt;
    wire wready_nxt  = ~(w_have & ~wr_go) & ~bvalid_nxt;

    // byte-lane mask from the strobes
    logic [31:0] lane_mask;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign lane_mask[gi*8 +: 8] = {8{wr_strb[gi]}};
        end
    endgenerate

    wire wr_cfg   = wr_go & (wr_addr == `ERF_OFS_RX_FILTER_CONFIG);
    wire wr_ctl   = wr_go & (wr_addr == `ERF_OFS_CONTROL);
    wire wr_stat  = wr_go & (wr_addr == `ERF_OFS_STATUS);
    wire wr_known = wr_cfg | wr_ctl | wr_stat;

    // config writes are dropped while reception runs; changes then would
    // tear a frame's decision between two settings
    wire cfg_we   = wr_cfg & ~rx_en_r;
    wire [31:0] cfg_mask = lane_mask & `ERF_CFG_WMASK;
    wire [31:0] cfg_nxt  = (cfg_r & ~cfg_mask) | (wr_data & cfg_mask);
    wire        rx_en_nxt = wr_strb[0] ? wr_data[`ERF_BIT_RX_EN] : rx_en_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
        end else begin
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            aw_held_r <= aw_have & ~wr_go;
            w_held_r  <= w_have & ~wr_go;
            if (aw_fire) begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
        end
    end

    // write response; status is read-only so a write there is only okayed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `ERF_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_known ? `ERF_RESP_OKAY : `ERF_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // configuration and receive enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r   <= `ERF_CFG_RESET;
            rx_en_r <= 1'b0;
        end else begin
            if (cfg_we) begin
                cfg_r <= cfg_nxt;
            end
            if (wr_ctl) begin
                rx_en_r <= rx_en_nxt;
            end
        end
    end

    // ------------------------------------------------------------------------
    // read channel, one read at a time, answer one cycle after address
    // ------------------------------------------------------------------------
    wire ar_fire = s_axi_arvalid & arready_r;
    wire arready_nxt = ~(ar_fire | (rvalid_r & ~s_axi_rready));
    wire [31:0] stat_word = {16'h0000, rej_cnt_r, acc_cnt_r};
    wire [31:0] ctl_word  = {31'h0, rx_en_r};
    wire rd_cfg  = s_axi_araddr == `ERF_OFS_RX_FILTER_CONFIG;
    wire rd_ctl  = s_axi_araddr == `ERF_OFS_CONTROL;
    wire rd_stat = s_axi_araddr == `ERF_OFS_STATUS;
    wire [31:0] rd_word = rd_cfg  ? cfg_r :
                          rd_ctl  ? ctl_word :
                          rd_stat ? stat_word : 32'h0000_0000;
    wire rd_known = rd_cfg | rd_ctl | rd_stat;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= `ERF_RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_known ? `ERF_RESP_OKAY : `ERF_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // address ready drops while an answer is pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
        end else begin
            arready_r <= arready_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // frame decision
    // ------------------------------------------------------------------------
    logic pm_ok;
    erf_pattern_judge u_judge (
        .sel            (cfg_r[`ERF_SEL_HI:`ERF_SEL_LO]),
        .invert         (cfg_r[`ERF_BIT_INVERT]),
        .csum_match     (csum_match),
        .dest_station   (dest_station),
        .dest_unicast   (dest_unicast),
        .dest_broadcast (dest_broadcast),
        .hash_match     (hash_match),
        .wake_packet    (wake_packet),
        .success        (pm_ok)
    );

    // class acceptance: a frame passes when any enabled class it falls in
    wire cls_crc_bad   = cfg_r[`ERF_BIT_CRC_BAD] & crc_bad;
    wire cls_crc_good  = cfg_r[`ERF_BIT_CRC_GOOD] & ~crc_bad;
    wire cls_short_err = cfg_r[`ERF_BIT_SHORT_ERR] & short_frame
                         & crc_bad;
    wire cls_short     = cfg_r[`ERF_BIT_SHORT] & short_frame;
    wire cls_single    = cfg_r[`ERF_BIT_SINGLE] & dest_unicast
                         & dest_station;
    wire cls_foreign   = cfg_r[`ERF_BIT_FOREIGN] & dest_unicast
                         & ~dest_station;
    wire cls_group     = cfg_r[`ERF_BIT_GROUP] & dest_multicast;
    wire cls_all       = cfg_r[`ERF_BIT_ALL] & dest_broadcast;
    wire cls_hash      = cfg_r[`ERF_BIT_HASH_EN] & hash_match;
    wire cls_wake      = cfg_r[`ERF_BIT_WAKE_EN] & wake_packet;
    wire class_ok = cls_crc_bad | cls_crc_good | cls_short_err | cls_short
                    | cls_single | cls_foreign | cls_group | cls_all
                    | cls_hash | cls_wake;

    // a frame counts only while receiving; no transmit path touches this
    wire judge  = frame_done & rx_en_r;
    wire take   = class_ok | pm_ok;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            accept_r  <= 1'b0;
            reject_r  <= 1'b0;
            hit_r     <= 1'b0;
            acc_cnt_r <= 8'h00;
            rej_cnt_r <= 8'h00;
        end else begin
            accept_r <= judge & take;
            reject_r <= judge & ~take;
            hit_r    <= judge & pm_ok;
            if (judge & take) begin
                acc_cnt_r <= acc_cnt_r + 8'h01; // saturating not needed
            end
            if (judge & ~take) begin
                rej_cnt_r <= rej_cnt_r + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------------------
    assign s_axi_awready  = awready_r;
    assign s_axi_wready   = wready_r;
    assign s_axi_bvalid   = bvalid_r;
    assign s_axi_bresp    = bresp_r;
    assign s_axi_arready  = arready_r;
    assign s_axi_rvalid   = rvalid_r;
    assign s_axi_rdata    = rdata_r;
    assign s_axi_rresp    = rresp_r;
    assign frame_accept   = accept_r;
    assign frame_reject   = reject_r;
    assign pattern_hit    = hit_r;
    assign receive_enable = rx_en_r;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    sequence s_frame_judged;
        frame_done & rx_en_r;
    endsequence

    property p_hash_class;
        @(posedge aclk) disable iff (!aresetn)
        (s_frame_judged and (cfg_r[15] & hash_match)) |=> frame_accept;
    endproperty
    a_hash_class: assert property (p_hash_class)
        else $error("hash match with hash enabled not accepted");

    property p_wake_class;
        @(posedge aclk) disable iff (!aresetn)
        (s_frame_judged and (cfg_r[14] & wake_packet)) |=> frame_accept;
    endproperty
    a_wake_class: assert property (p_wake_class)
        else $error("wake packet with filter enabled not accepted");

    property p_invert;
        @(posedge aclk) disable iff (!aresetn)
        (s_frame_judged and (cfg_r[11:8] == 4'b0001))
        |=> pattern_hit == ($past(cfg_r[12]) ^ $past(csum_match));
    endproperty
    a_invert: assert property (p_invert)
        else $error("checksum inversion result wrong");

    property p_pm_off;
        @(posedge aclk) disable iff (!aresetn)
        (cfg_r[11:8] == 4'b0000) ##1 (cfg_r[11:8] == 4'b0000) |-> !pattern_hit;
    endproperty
    a_pm_off: assert property (p_pm_off)
        else $error("pattern hit while matching disabled");

    property p_station;
        @(posedge aclk) disable iff (!aresetn)
        (s_frame_judged and (cfg_r[11:9] == 3'b001) and !dest_station)
        |=> !pattern_hit;
    endproperty
    a_station: assert property (p_station)
        else $error("station mode hit without station address");

    property p_unicast;
        @(posedge aclk) disable iff (!aresetn)
        (s_frame_judged and (cfg_r[11:9] == 3'b010) and !dest_unicast)
        |=> !pattern_hit;
    endproperty
    a_unicast: assert property (p_unicast)
        else $error("unicast mode hit without unicast address");

    property p_bcast;
        @(posedge aclk) disable iff (!aresetn)
        (s_frame_judged and (cfg_r[11:9] == 3'b011) and !dest_broadcast)
        |=> !pattern_hit;
    endproperty
    a_bcast: assert property (p_bcast)
        else $error("broadcast mode hit without broadcast address");

    property p_hash_mode;
        @(posedge aclk) disable iff (!aresetn)
        (s_frame_judged and (cfg_r[11:8] == 4'b1000) and !cfg_r[15]
         and hash_match and (cfg_r[12] ^ csum_match)) |=> pattern_hit;
    endproperty
    a_hash_mode: assert property (p_hash_mode)
        else $error("hash mode ignored match with hash filter off");

    property p_wake_mode;
        @(posedge aclk) disable iff (!aresetn)
        (s_frame_judged and (cfg_r[11:8] == 4'b1001) and !cfg_r[14]
         and wake_packet and (cfg_r[12] ^ csum_match)) |=> pattern_hit;
    endproperty
    a_wake_mode: assert property (p_wake_mode)
        else $error("wake mode ignored packet with wake filter off");

    property p_rx_only;
        @(posedge aclk) disable iff (!aresetn)
        !rx_en_r |=> !frame_accept && !frame_reject;
    endproperty
    a_rx_only: assert property (p_rx_only)
        else $error("frame judged while receive disabled");

    property p_cfg_frozen;
        @(posedge aclk) disable iff (!aresetn)
        rx_en_r ##1 rx_en_r |-> $stable(cfg_r);
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen)
        else $error("filter config changed while receiving");

    property p_bcast_class;
        @(posedge aclk) disable iff (!aresetn)
        (s_frame_judged and cfg_r[0] and dest_broadcast) |=> frame_accept;
    endproperty
    a_bcast_class: assert property (p_bcast_class)
        else $error("broadcast frame not accepted with class enabled");
endmodule

// ===== erf_frame_src.sv
// receive path model: presents one classified frame per call
`timescale 1ns/1ps
module erf_frame_src (
    input  wire logic  aclk,
    output logic       frame_done,
    output logic [8:0] cls
);
    // lines are not held after a frame; the inverse stops stale values
    // from passing for a fresh classification
    initial begin
        frame_done = 1'b0;
        cls        = 9'h000;
    end
    // call right after a rising edge; the frame is taken at the next one
    task automatic send(input logic [8:0] v);
        frame_done <= 1'b1;
        cls        <= v;
        @(posedge aclk);
        frame_done <= 1'b0;
        cls        <= ~v;
    endtask
endmodule

// ===== erf_rx_filter_tb_top.sv
// self-checking bench for the receive frame filter
`timescale 1ns/1ps
`include "erf_regs.svh"
module erf_rx_filter_tb_top;
    import erf_pkg::*;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    erf_resp_t   bresp, rresp;
    logic        frame_done, acc, rej, hit, rx_en;
    logic [8:0]  cls;
    logic [7:0]  n_acc, n_rej;
    int          err_count, checks;

    erf_rx_filter i_erf_rx_filter (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .frame_done(frame_done),
        .crc_bad(cls[8]), .short_frame(cls[7]),
        .dest_station(cls[6]), .dest_unicast(cls[5]),
        .dest_multicast(cls[4]), .dest_broadcast(cls[3]),
        .hash_match(cls[2]), .wake_packet(cls[1]),
        .csum_match(cls[0]), .frame_accept(acc),
        .frame_reject(rej), .pattern_hit(hit),
        .receive_enable(rx_en)
    );
    erf_frame_src i_erf_frame_src (
        .aclk(aclk), .frame_done(frame_done), .cls(cls)
    );

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // ------------------------------------------------------------------
    // reference and reporting
    // ------------------------------------------------------------------
    // cls: crc_bad short station unicast multicast bcast hash wake csum
    function automatic logic exp_hit(logic [31:0] c, logic [8:0] v);
        logic x;
        x = c[12] ^ v[0];
        case (c[11:8])
            4'h1:       return x;
            4'h2, 4'h3: return x & v[6];
            4'h4, 4'h5: return x & v[5];
            4'h6, 4'h7: return x & v[3];
            4'h8:       return x & v[2];
            4'h9:       return x & v[1];
            default:    return 1'b0;
        endcase
    endfunction
    function automatic logic exp_acc(logic [31:0] c, logic [8:0] v);
        logic [7:0] k;
        k = {v[8], ~v[8], v[7] & v[8], v[7], v[5] & v[6], v[5] & ~v[6],
             v[4], v[3]};
        return (|(k & c[7:0])) | (c[15] & v[2]) | (c[14] & v[1])
               | exp_hit(c, v);
    endfunction
    task automatic chk32(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(string nm, logic e, logic g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic tmo(int n);
        if (n >= 50) begin
            err_count++;
            $display("[ERR] bus answer expected 1 seen 0");
            close_out();
        end
    endtask

    // ------------------------------------------------------------------
    // register bus master
    // ------------------------------------------------------------------
    // each call first lets an edge pass so ready never toggles twice
    task automatic wr(logic [3:0] a, logic [31:0] d, erf_resp_t er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        bready <= 1'b0;
        tmo(n);
        chk32("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] e, erf_resp_t er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        rready <= 1'b0;
        tmo(n);
        chk32("rdata", e, rdata);
        chk32("rresp", {30'h0, er}, {30'h0, rresp});
    endtask
    // reception is stopped around every change of the filter setup
    task automatic set_cfg(logic [31:0] c);
        wr(`ERF_OFS_CONTROL, 32'h0, `ERF_RESP_OKAY);
        wr(`ERF_OFS_RX_FILTER_CONFIG, c, `ERF_RESP_OKAY);
        wr(`ERF_OFS_CONTROL, 32'h1, `ERF_RESP_OKAY);
    endtask
    // every classification combination, one idle cycle between frames
    task automatic sweep(logic [31:0] c);
        logic a;
        for (int v = 0; v < 512; v++) begin
            i_erf_frame_src.send(9'(v));
            #1;
            a = exp_acc(c, 9'(v));
            chk1("pattern_hit", exp_hit(c, 9'(v)), hit);
            chk1("frame_accept", a, acc);
            chk1("frame_reject", ~a, rej);
            if (a) n_acc++;
            else n_rej++;
            @(posedge aclk);
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd(`ERF_OFS_RX_FILTER_CONFIG, `ERF_CFG_RESET, `ERF_RESP_OKAY);
        rd(`ERF_OFS_CONTROL, 32'h0, `ERF_RESP_OKAY);
        rd(`ERF_OFS_STATUS, 32'h0, `ERF_RESP_OKAY);
        rd(4'hc, 32'h0, `ERF_RESP_SLVERR);
        wr(4'hc, 32'h1, `ERF_RESP_SLVERR);
        chk1("receive_enable", 1'b0, rx_en);
    endtask
    // unimplemented bits read 0; status ignores writes
    task automatic t_mask;
        wr(`ERF_OFS_RX_FILTER_CONFIG, 32'hffff_ffff, `ERF_RESP_OKAY);
        rd(`ERF_OFS_RX_FILTER_CONFIG, `ERF_CFG_WMASK, `ERF_RESP_OKAY);
        // only the strobed lane may change
        wstrb <= 4'h2;
        wr(`ERF_OFS_RX_FILTER_CONFIG, 32'h0, `ERF_RESP_OKAY);
        wstrb <= 4'hf;
        rd(`ERF_OFS_RX_FILTER_CONFIG, 32'h0000_00ff, `ERF_RESP_OKAY);
        wr(`ERF_OFS_STATUS, 32'hffff_ffff, `ERF_RESP_OKAY);
        rd(`ERF_OFS_STATUS, 32'h0, `ERF_RESP_OKAY);
    endtask
    // accept-all setup, yet frames must go unjudged while stopped
    task automatic t_idle;
        for (int v = 0; v < 8; v++) begin
            i_erf_frame_src.send(9'(v * 61));
            #1;
            chk1("frame_accept", 1'b0, acc);
            chk1("frame_reject", 1'b0, rej);
            chk1("pattern_hit", 1'b0, hit);
            @(posedge aclk);
        end
    endtask
    // a setup write during reception is dropped
    task automatic t_lock;
        wr(`ERF_OFS_CONTROL, 32'h1, `ERF_RESP_OKAY);
        chk1("receive_enable", 1'b1, rx_en);
        wr(`ERF_OFS_RX_FILTER_CONFIG, 32'h100, `ERF_RESP_OKAY);
        rd(`ERF_OFS_RX_FILTER_CONFIG, 32'h0000_00ff, `ERF_RESP_OKAY);
    endtask
    // all select codes with both checksum senses, filter enables off
    task automatic t_modes;
        for (int m = 0; m < 32; m++) begin
            set_cfg({19'h0, 5'(m), 8'h00});
            sweep({19'h0, 5'(m), 8'h00});
        end
    endtask
    // each enable bit alone
    task automatic t_enables;
        for (int b = 0; b < 16; b++) begin
            if (b < 8 || b > 13) begin
                set_cfg(32'h1 << b);
                sweep(32'h1 << b);
            end
        end
    endtask
    task automatic t_status;
        rd(`ERF_OFS_STATUS, {16'h0, n_rej, n_acc}, `ERF_RESP_OKAY);
    endtask

    initial begin
        aresetn   = 1'b0;
        awaddr    = 4'h0;
        awvalid   = 1'b0;
        wdata     = 32'h0;
        wstrb     = 4'hf;
        wvalid    = 1'b0;
        bready    = 1'b0;
        araddr    = 4'h0;
        arvalid   = 1'b0;
        rready    = 1'b0;
        err_count = 0;
        checks    = 0;
        n_acc     = 8'h00;
        n_rej     = 8'h00;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_mask();
        t_idle();
        t_lock();
        t_modes();
        t_enables();
        t_status();
        close_out();
    end
endmodule
